/* File: byte_fifo.sv */
// first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic flush_in,
  // fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // full and empty come straight from the occupancy count
  assign in_ready_out = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem_q[rp_q];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // storage has no reset, only pointers matter
  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem_q[wp_q] <= in_data_in;
    end
  end

  // pointers and count
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || flush_in) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* File: diskette_cmd_host_port_tb_top.sv */
// bench for the diskette host port command, execution and result phases
`timescale 1ns/1ps
`default_nettype none
module diskette_cmd_host_port_tb_top;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [9:0] addr = 10'h000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdat, st, sec, fd, lsec, gap, cyl, rec;
  logic [4:0] op;
  logic [1:0] drv;
  logic start, done, fv, fr, trdy, hsel, hld, sdir;
  logic [15:0] nb;
  logic [7:0] cmd [9] = '{8'h06, 8'h05, 8'h05, 8'h01, 8'h03, 8'h00, 8'h09, 8'h1b, 8'h2a};
  logic [7:0] res [7] = '{8'h45, 8'h40, 8'h40, 8'h05, 8'h01, 8'h04, 8'h00};
  int error_cnt = 0;
  int checks_done = 0;
  always #2 ref_clk_in = ~ref_clk_in;
  fdc_host_port #(.CYC_PER_MS(8)) dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr), .rd_in(rd),
    .wr_in(wr), .wr_data_in(wd), .rd_data_out(rdat), .exec_start_out(start), .exec_op_out(op),
    .drive_select_field_out(drv), .head_select_out(hsel), .cylinder_out(cyl), .sector_out(rec),
    .sector_bytes_out(nb), .last_sector_on_track_out(lsec), .inter_sector_gap_length_out(gap),
    .exec_done_in(done),
    .exec_st0_in(st), .exec_st1_in(st), .exec_st2_in(st), .exec_sector_in(sec), .fromdisk_valid_in(fv),
    .fromdisk_data_in(fd), .fromdisk_ready_out(fr), .todisk_valid_out(), .todisk_data_out(),
    .todisk_ready_in(trdy), .step_out(), .step_dir_out(sdir), .head_load_out(hld), .write_protect_in(1'b0),
    .drive_ready_in(1'b1));
  media_model eng (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .start_in(start), .done_out(done), .st_out(st),
    .sector_out(sec), .valid_out(fv), .data_out(fd), .ready_in(fr), .sink_ready_out(trdy));
  task automatic test_done();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one strobe cycle; read data is settled by the next falling edge
  task automatic acc(input logic [9:0] a, input logic r, input logic [7:0] d);
    @(negedge ref_clk_in);
    addr = a;
    rd = r;
    wr = ~r;
    wd = d;
    @(negedge ref_clk_in);
    rd = 1'b0;
    wr = 1'b0;
  endtask
  // bounded wait for ready with the wanted direction
  task automatic poll(input logic dir);
    for (int i = 0; i < 3000; i++) begin
      acc(fdc_pkg::MSR_ADDR, 1'b1, 8'h00);
      if (rdat[7] === 1'b1 && rdat[6] === dir) return;
    end
    error_cnt++;
    test_done();
  endtask
  // bounded wait for a drive's seek bit to drop
  task automatic settle(input int b);
    for (int i = 0; i < 400; i++) begin
      acc(fdc_pkg::MSR_ADDR, 1'b1, 8'h00);
      if (rdat[b] === 1'b0) return;
    end
    error_cnt++;
    test_done();
  endtask
  task automatic put(input logic [7:0] b);
    poll(1'b0);
    acc(fdc_pkg::DATA_ADDR, 1'b0, b);
  endtask
  task automatic get(input logic [7:0] e);
    poll(1'b1);
    acc(fdc_pkg::DATA_ADDR, 1'b1, 8'h00);
    chk(16'(rdat), 16'(e));
  endtask
  initial begin
    repeat (20) @(negedge ref_clk_in);
    rst_in = 1'b0;
    acc(fdc_pkg::MSR_ADDR, 1'b1, 8'h00);
    chk(16'(rdat), 16'h0080);
    acc(10'h3f0, 1'b1, 8'h00);
    chk(16'(rdat), 16'h0000);
    put(8'h03);
    put(8'h00);
    put(8'h03);
    put(8'h1f);
    get(fdc_pkg::ST0_INVALID);
    put(8'h08);
    get(8'h80);
    // seek each drive one cylinder and collect the interrupt status
    for (int d = 0; d < 2; d++) begin
      put(8'h0f);
      put(8'(d));
      put(8'h01);
      acc(fdc_pkg::MSR_ADDR, 1'b1, 8'h00);
      chk(16'(rdat), 16'h0080 | 16'(1 << d));
      settle(d);
      chk(16'({sdir, rdat}), 16'h0180);
      put(8'h08);
      get(8'h20 | 8'(d));
      get(8'h01);
    end
    // recalibrate drive 0 back to cylinder 0, then read its drive status
    put(8'h07);
    put(8'h00);
    acc(fdc_pkg::MSR_ADDR, 1'b1, 8'h00);
    chk(16'(rdat), 16'h0081);
    settle(0);
    chk(16'({sdir, rdat}), 16'h0080);
    put(8'h08);
    get(8'h20);
    get(8'h00);
    put(8'h04);
    put(8'h04);
    get(8'h3c);
    foreach (cmd[i]) put(cmd[i]);
    acc(fdc_pkg::MSR_ADDR, 1'b1, 8'h00);
    chk(16'(rdat & 8'h30), 16'h0010);
    chk(16'(hld), 16'h0001);
    chk(nb, 16'h002a);
    chk({lsec, gap}, 16'h091b);
    chk({3'h0, op, cyl}, 16'h0605);
    chk({rec, 5'h00, hsel, drv}, 16'h0305);
    get(8'ha0);
    acc(fdc_pkg::MSR_ADDR, 1'b1, 8'h00);
    chk(16'(rdat), 16'h00f0);
    get(8'ha1);
    foreach (res[i]) get(res[i]);
    acc(fdc_pkg::MSR_ADDR, 1'b1, 8'h00);
    chk(16'(rdat), 16'h0080);
    test_done();
  end
endmodule
`default_nettype wire

/* File: fdc_host_port.sv */
// diskette controller host command, execution and result port
`timescale 1ns/1ps
`default_nettype none
module fdc_host_port #(
  parameter int unsigned CYC_PER_MS = fdc_pkg::CYC_PER_MS
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // host i/o port
  input wire logic [9:0] addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [7:0] wr_data_in,
  output logic [7:0] rd_data_out,
  // execution request to the media engine
  output logic exec_start_out,
  output logic [4:0] exec_op_out,
  output logic [1:0] drive_select_field_out,
  output logic head_select_out,
  output logic [7:0] cylinder_out,
  output logic [7:0] sector_out,
  output logic [15:0] sector_bytes_out,
  output logic [7:0] last_sector_on_track_out,
  output logic [7:0] inter_sector_gap_length_out,
  input wire logic exec_done_in,
  input wire logic [7:0] exec_st0_in,
  input wire logic [7:0] exec_st1_in,
  input wire logic [7:0] exec_st2_in,
  input wire logic [7:0] exec_sector_in,
  // data from the disk
  input wire logic fromdisk_valid_in,
  input wire logic [7:0] fromdisk_data_in,
  output logic fromdisk_ready_out,
  // data to the disk
  output logic todisk_valid_out,
  output logic [7:0] todisk_data_out,
  input wire logic todisk_ready_in,
  // drive signals
  output logic step_out,
  output logic step_dir_out,
  output logic head_load_out,
  input wire logic write_protect_in,
  input wire logic drive_ready_in
);
  fdc_pkg::phase_t phase_q;
  logic [4:0] op_q;
  logic [3:0] cnt_q;
  logic [3:0] need_q;
  logic [7:0] par_q [9];
  logic [7:0] res_q [7];
  logic [2:0] rcnt_q;
  logic [2:0] rlen_q;
  logic todisk_q;
  logic [3:0] step_code_q;
  logic [3:0] unload_code_q;
  logic [6:0] hlt_q;
  logic nondma_q;
  logic seek_act_q;
  logic seek_drv_q;
  logic [7:0] ncn_q;
  logic [7:0] pcn_q [2];
  logic [1:0] int_pend_q;
  logic head_loaded_q;
  logic rqm;
  logic dio;
  logic [7:0] msr;
  logic wr_dp;
  logic rd_dp;
  logic last_par;
  logic seek_go;
  logic sense_go;
  logic sense_drv;
  logic seek_unit;
  logic load_start;
  logic load_done;
  logic unload_start;
  logic unload_done;
  logic step_start;
  logic step_exp;
  logic fifo_in_valid;
  logic [7:0] fifo_in_data;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic fifo_out_ready;

  // parameter bytes after the opcode, PARAMS_BAD when undecoded
  function automatic logic [3:0] params_of(input logic [4:0] op);
    case (op)
      fdc_pkg::OP_READ, fdc_pkg::OP_READ_DEL, fdc_pkg::OP_READ_TRK,
      fdc_pkg::OP_WRITE, fdc_pkg::OP_WRITE_DEL: params_of = 4'h8;
      fdc_pkg::OP_FORMAT: params_of = 4'h5;
      fdc_pkg::OP_SPECIFY, fdc_pkg::OP_SEEK: params_of = 4'h2;
      fdc_pkg::OP_READ_ID, fdc_pkg::OP_RECAL, fdc_pkg::OP_SENSE_DRV: params_of = 4'h1;
      fdc_pkg::OP_SENSE_INT: params_of = 4'h0;
      default: params_of = fdc_pkg::PARAMS_BAD;
    endcase
  endfunction

  // bytes per sector from the size code
  function automatic logic [15:0] sector_bytes(input logic [7:0] n, input logic [7:0] transfer_length_limit);
    if (n == 8'h00) begin
      sector_bytes = {8'h00, transfer_length_limit};
    end else begin
      sector_bytes = 16'h0080 << n[2:0];
    end
  endfunction

  // host strobes that really move a byte; others are ignored
  assign wr_dp = wr_in && (addr_in == fdc_pkg::DATA_ADDR) && rqm && !dio;
  assign rd_dp = rd_in && (addr_in == fdc_pkg::DATA_ADDR) && rqm && dio;
  assign last_par = (cnt_q == need_q - 4'h1);

  // ready and direction per phase
  always_comb begin
    rqm = 1'b0;
    dio = 1'b0;
    case (phase_q)
      fdc_pkg::PH_IDLE, fdc_pkg::PH_CMD: begin
        rqm = 1'b1;
      end
      fdc_pkg::PH_EXEC: begin
        rqm = todisk_q ? fifo_in_ready : fifo_out_valid;
        dio = !todisk_q;
      end
      fdc_pkg::PH_RESULT: begin
        rqm = 1'b1;
        dio = 1'b1;
      end
      default: begin
        rqm = 1'b0;
      end
    endcase
  end

  // handshake status byte
  always_comb begin
    msr = 8'h00;
    msr[fdc_pkg::RQM_BIT] = rqm;
    msr[fdc_pkg::DIO_BIT] = dio;
    msr[fdc_pkg::NDMA_BIT] = nondma_q && (phase_q == fdc_pkg::PH_EXEC);
    msr[fdc_pkg::BUSY_BIT] = (phase_q != fdc_pkg::PH_IDLE);
    msr[fdc_pkg::DRV1_BIT] = seek_act_q && seek_drv_q;
    msr[fdc_pkg::DRV0_BIT] = seek_act_q && !seek_drv_q;
  end

  // seek, sense and head-load events from the host command bytes
  assign seek_go = (phase_q == fdc_pkg::PH_CMD) && wr_dp && last_par &&
                   (op_q == fdc_pkg::OP_SEEK || op_q == fdc_pkg::OP_RECAL);
  assign sense_go = (phase_q == fdc_pkg::PH_IDLE) && wr_dp &&
                    (wr_data_in[4:0] == fdc_pkg::OP_SENSE_INT);
  assign sense_drv = !int_pend_q[0];
  assign load_start = (phase_q == fdc_pkg::PH_CMD) && wr_dp && last_par &&
                      (params_of(op_q) >= 4'h5 || op_q == fdc_pkg::OP_READ_ID) &&
                      (!head_loaded_q || unload_done); // head unloading this cycle must load again
  // recal carries its unit in its only byte, which is still on the bus
  assign seek_unit = (op_q == fdc_pkg::OP_RECAL) ? wr_data_in[0] : par_q[fdc_pkg::P_UNIT][0];
  assign unload_start = (phase_q == fdc_pkg::PH_EXEC) && exec_done_in;

  // command sequencer: phases, parameter capture and result stack
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      phase_q <= fdc_pkg::PH_IDLE;
      op_q <= 5'h00;
      cnt_q <= 4'h0;
      need_q <= 4'h0;
      rcnt_q <= 3'h0;
      rlen_q <= 3'h0;
      todisk_q <= 1'b0;
      exec_start_out <= 1'b0;
      step_code_q <= 4'h0;
      unload_code_q <= 4'h0;
      hlt_q <= 7'h00;
      nondma_q <= 1'b0;
    end else begin
      exec_start_out <= 1'b0;
      case (phase_q)
        fdc_pkg::PH_IDLE: begin
          if (wr_dp) begin
            op_q <= wr_data_in[4:0];
            cnt_q <= 4'h0;
            need_q <= params_of(wr_data_in[4:0]);
            rcnt_q <= 3'h0;
            if (params_of(wr_data_in[4:0]) == fdc_pkg::PARAMS_BAD) begin
              res_q[0] <= fdc_pkg::ST0_INVALID;
              rlen_q <= 3'h1;
              phase_q <= fdc_pkg::PH_RESULT;
            end else if (wr_data_in[4:0] == fdc_pkg::OP_SENSE_INT) begin
              res_q[0] <= (int_pend_q == 2'b00) ? fdc_pkg::ST0_INVALID :
                          (fdc_pkg::ST0_SEEK_END | {7'h00, sense_drv});
              res_q[1] <= pcn_q[sense_drv];
              rlen_q <= (int_pend_q == 2'b00) ? 3'h1 : 3'h2;
              phase_q <= fdc_pkg::PH_RESULT;
            end else begin
              phase_q <= fdc_pkg::PH_CMD;
            end
          end
        end
        fdc_pkg::PH_CMD: begin
          if (wr_dp) begin
            par_q[cnt_q] <= wr_data_in;
            cnt_q <= cnt_q + 4'h1;
            if (last_par) begin
              case (op_q)
                fdc_pkg::OP_SPECIFY: begin
                  step_code_q <= par_q[0][7:4];
                  unload_code_q <= par_q[0][3:0];
                  hlt_q <= wr_data_in[7:1];
                  nondma_q <= wr_data_in[fdc_pkg::P_ND_BIT];
                  phase_q <= fdc_pkg::PH_IDLE;
                end
                fdc_pkg::OP_SEEK, fdc_pkg::OP_RECAL: begin
                  phase_q <= fdc_pkg::PH_IDLE;
                end
                fdc_pkg::OP_SENSE_DRV: begin
                  res_q[0] <= {1'b0, write_protect_in, drive_ready_in,
                               pcn_q[wr_data_in[0]] == 8'h00, 1'b1, wr_data_in[2:0]};
                  rlen_q <= 3'h1;
                  phase_q <= fdc_pkg::PH_RESULT;
                end
                default: begin
                  todisk_q <= (op_q == fdc_pkg::OP_WRITE) || (op_q == fdc_pkg::OP_WRITE_DEL) ||
                              (op_q == fdc_pkg::OP_FORMAT);
                  phase_q <= fdc_pkg::PH_HLOAD;
                end
              endcase
            end
          end
        end
        fdc_pkg::PH_HLOAD: begin
          if (head_loaded_q || load_done) begin
            exec_start_out <= 1'b1;
            phase_q <= fdc_pkg::PH_EXEC;
          end
        end
        fdc_pkg::PH_EXEC: begin
          if (exec_done_in) begin
            res_q[0] <= {exec_st0_in[7:3], head_select_out, drive_select_field_out};
            res_q[1] <= exec_st1_in;
            res_q[2] <= exec_st2_in;
            res_q[3] <= par_q[fdc_pkg::P_CYL];
            res_q[4] <= par_q[fdc_pkg::P_HEAD];
            res_q[5] <= exec_sector_in;
            res_q[6] <= par_q[fdc_pkg::P_SIZE];
            rlen_q <= fdc_pkg::RES_LEN_DATA;
            phase_q <= fdc_pkg::PH_RESULT;
          end
        end
        fdc_pkg::PH_RESULT: begin
          if (rd_dp) begin
            rcnt_q <= rcnt_q + 3'h1;
            if (rcnt_q == rlen_q - 3'h1) begin
              phase_q <= fdc_pkg::PH_IDLE;
            end
          end
        end
        default: begin
          phase_q <= fdc_pkg::PH_IDLE;
        end
      endcase
    end
  end

  // read data: the status byte, one result stack register or a buffer byte; anything else reads zero
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rd_data_out <= 8'h00;
    end else if (rd_in) begin
      if (addr_in == fdc_pkg::MSR_ADDR) begin
        rd_data_out <= msr;
      end else if (rd_dp && phase_q == fdc_pkg::PH_RESULT) begin
        rd_data_out <= res_q[rcnt_q];
      end else if (rd_dp) begin
        rd_data_out <= fifo_out_data;
      end else begin
        rd_data_out <= 8'h00;
      end
    end
  end

  // media request fields come from the captured opcode and parameter bytes
  assign exec_op_out = op_q;
  assign drive_select_field_out = par_q[fdc_pkg::P_UNIT][1:0];
  assign head_select_out = par_q[fdc_pkg::P_UNIT][fdc_pkg::P_HEAD_SEL_BIT];
  assign cylinder_out = par_q[fdc_pkg::P_CYL];
  assign sector_out = par_q[fdc_pkg::P_REC];
  assign sector_bytes_out = sector_bytes(par_q[fdc_pkg::P_SIZE], par_q[fdc_pkg::P_XFER_LEN]);
  assign last_sector_on_track_out = par_q[fdc_pkg::P_LAST_SEC];
  assign inter_sector_gap_length_out = (op_q == fdc_pkg::OP_FORMAT) ?
         par_q[fdc_pkg::P_FMT_GAP] : par_q[fdc_pkg::P_GAP];

  // execution data buffer, direction set by the command
  assign fifo_in_valid = (phase_q == fdc_pkg::PH_EXEC) &&
                         (todisk_q ? wr_dp : fromdisk_valid_in);
  assign fifo_in_data = todisk_q ? wr_data_in : fromdisk_data_in;
  assign fromdisk_ready_out = (phase_q == fdc_pkg::PH_EXEC) && !todisk_q && fifo_in_ready;
  assign todisk_valid_out = todisk_q && fifo_out_valid;
  assign todisk_data_out = fifo_out_data;
  assign fifo_out_ready = todisk_q ? todisk_ready_in : rd_dp;

  byte_fifo #(.WIDTH(fdc_pkg::BYTE_W), .DEPTH(fdc_pkg::FIFO_DEPTH)) u_fifo (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .flush_in(unload_start),
    .in_valid_in(fifo_in_valid),
    .in_data_in(fifo_in_data),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(fifo_out_valid),
    .out_data_out(fifo_out_data),
    .out_ready_in(fifo_out_ready)
  );

  // head load and unload; a new load cancels a pending unload
  ms_delay_timer #(.CYC_PER_MS(CYC_PER_MS)) u_load_tmr (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .start_in(load_start),
    .abort_in(1'b0),
    .ms_in({hlt_q, 1'b0}),
    .busy_out(),
    .expired_out(load_done)
  );
  ms_delay_timer #(.CYC_PER_MS(CYC_PER_MS)) u_unload_tmr (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .start_in(unload_start),
    .abort_in(phase_q == fdc_pkg::PH_HLOAD),
    .ms_in((unload_code_q == 4'h0) ? fdc_pkg::UNLOAD_MIN_MS : {unload_code_q, 4'h0}),
    .busy_out(),
    .expired_out(unload_done)
  );

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      head_loaded_q <= 1'b0;
    end else if (load_done) begin
      head_loaded_q <= 1'b1;
    end else if (unload_done) begin
      head_loaded_q <= 1'b0;
    end
  end
  assign head_load_out = head_loaded_q || (phase_q == fdc_pkg::PH_HLOAD);

  // step engine: one step per interval until the target cylinder
  ms_delay_timer #(.CYC_PER_MS(CYC_PER_MS)) u_step_tmr (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .start_in(step_start),
    .abort_in(1'b0),
    .ms_in({3'h0, fdc_pkg::STEP_BASE_MS - {1'b0, step_code_q}}),
    .busy_out(),
    .expired_out(step_exp)
  );
  assign step_start = (seek_go && !seek_act_q) ||
                      (step_exp && pcn_q[seek_drv_q] != ncn_q);

  // a second seek while one runs is dropped; set beats a sense clear
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      seek_act_q <= 1'b0;
      seek_drv_q <= 1'b0;
      ncn_q <= 8'h00;
      pcn_q[0] <= 8'h00;
      pcn_q[1] <= 8'h00;
      int_pend_q <= 2'b00;
      step_out <= 1'b0;
      step_dir_out <= 1'b0;
    end else begin
      step_out <= 1'b0;
      if (sense_go && int_pend_q != 2'b00) begin
        int_pend_q[sense_drv] <= 1'b0;
      end
      if (seek_go && !seek_act_q) begin
        seek_act_q <= 1'b1;
        seek_drv_q <= seek_unit;
        ncn_q <= (op_q == fdc_pkg::OP_SEEK) ? wr_data_in : 8'h00;
      end else if (step_exp) begin
        if (pcn_q[seek_drv_q] == ncn_q) begin
          seek_act_q <= 1'b0;
          int_pend_q[seek_drv_q] <= 1'b1;
        end else begin
          step_out <= 1'b1;
          step_dir_out <= (ncn_q > pcn_q[seek_drv_q]);
          pcn_q[seek_drv_q] <= (ncn_q > pcn_q[seek_drv_q]) ?
                               pcn_q[seek_drv_q] + 8'h01 : pcn_q[seek_drv_q] - 8'h01;
        end
      end
    end
  end

  // checks
  AST_RESULT_READY: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    phase_q == fdc_pkg::PH_RESULT |-> msr[7] && msr[6]) else $error("result phase not ready");
  AST_WRITE_DIR: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    phase_q == fdc_pkg::PH_EXEC && todisk_q |-> !msr[6]) else $error("wrong direction on write");
  AST_NDMA_SHOW: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    phase_q == fdc_pkg::PH_EXEC |-> msr[5] == nondma_q) else $error("non-dma bit wrong");
  AST_BUSY: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    phase_q == fdc_pkg::PH_HLOAD |-> msr[4] && !msr[7]) else $error("busy missing while loading");
  AST_SEEK_BITS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    seek_go && !seek_act_q && seek_unit |=> msr[1] && !msr[0]) else $error("drive 1 seek not shown");
  AST_RSVD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    msr[3:2] == 2'b00) else $error("reserved bits set");
  AST_EXEC_ENTRY: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    phase_q == fdc_pkg::PH_HLOAD && (head_loaded_q || load_done) |=> phase_q == fdc_pkg::PH_EXEC && exec_start_out)
    else $error("execution not started");
  AST_RESULT_ENTRY: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    phase_q == fdc_pkg::PH_EXEC && exec_done_in |=> phase_q == fdc_pkg::PH_RESULT ##0 rlen_q == 3'h7)
    else $error("result phase missed");
  AST_BAD_OP: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    phase_q == fdc_pkg::PH_IDLE && wr_dp && params_of(wr_data_in[4:0]) == fdc_pkg::PARAMS_BAD
    |=> phase_q == fdc_pkg::PH_RESULT && res_q[0] == 8'h80) else $error("invalid opcode not flagged");
  AST_XFER_LEN: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    par_q[fdc_pkg::P_SIZE] == 8'h00 |-> sector_bytes_out == {8'h00, par_q[fdc_pkg::P_XFER_LEN]})
    else $error("data length not used");
endmodule
`default_nettype wire

/* File: fdc_pkg.sv */
// shared constants for the diskette command port
`default_nettype none
package fdc_pkg;
  // host addresses
  localparam logic [9:0] MSR_ADDR = 10'h3f4;
  localparam logic [9:0] DATA_ADDR = 10'h3f5;
  // handshake status bit positions
  localparam int RQM_BIT = 7;
  localparam int DIO_BIT = 6;
  localparam int NDMA_BIT = 5;
  localparam int BUSY_BIT = 4;
  localparam int DRV1_BIT = 1;
  localparam int DRV0_BIT = 0;
  // command codes, low five bits of the first byte
  localparam logic [4:0] OP_READ = 5'h06;
  localparam logic [4:0] OP_READ_DEL = 5'h0c;
  localparam logic [4:0] OP_READ_TRK = 5'h02;
  localparam logic [4:0] OP_READ_ID = 5'h0a;
  localparam logic [4:0] OP_WRITE = 5'h05;
  localparam logic [4:0] OP_WRITE_DEL = 5'h09;
  localparam logic [4:0] OP_FORMAT = 5'h0d;
  localparam logic [4:0] OP_RECAL = 5'h07;
  localparam logic [4:0] OP_SENSE_INT = 5'h08;
  localparam logic [4:0] OP_SPECIFY = 5'h03;
  localparam logic [4:0] OP_SENSE_DRV = 5'h04;
  localparam logic [4:0] OP_SEEK = 5'h0f;
  localparam logic [3:0] PARAMS_BAD = 4'hf;
  // parameter byte slots of the data commands
  localparam int P_UNIT = 0;
  localparam int P_CYL = 1;
  localparam int P_HEAD = 2;
  localparam int P_REC = 3;
  localparam int P_SIZE = 4;
  localparam int P_LAST_SEC = 5;
  localparam int P_GAP = 6;
  localparam int P_XFER_LEN = 7;
  localparam int P_FMT_GAP = 3;
  localparam int P_HEAD_SEL_BIT = 2;
  localparam int P_ND_BIT = 0;
  // status byte values
  localparam logic [7:0] ST0_INVALID = 8'h80;
  localparam logic [7:0] ST0_SEEK_END = 8'h20;
  localparam logic [2:0] RES_LEN_DATA = 3'h7;
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam logic [4:0] STEP_BASE_MS = 5'h10;
  localparam logic [7:0] UNLOAD_MIN_MS = 8'h10;
  // data buffer
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 16;
  // command phases
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_CMD = 3'b001,
    PH_HLOAD = 3'b010,
    PH_EXEC = 3'b011,
    PH_RESULT = 3'b100
  } phase_t;
endpackage
`default_nettype wire

/* File: media_model.sv */
// media engine stand-in for the far side of the port
`timescale 1ns/1ps
`default_nettype none
module media_model (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // execution
  input wire logic start_in,
  output logic done_out,
  output logic [7:0] st_out,
  output logic [7:0] sector_out,
  // streams
  output logic valid_out,
  output logic [7:0] data_out,
  input wire logic ready_in,
  output logic sink_ready_out
);
  logic act_q;
  logic [7:0] cnt_q;
  // two bytes, then a long gap so the host drains before the flush at done
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || start_in) begin
      act_q <= start_in;
      cnt_q <= 8'h00;
    end else if (act_q && (cnt_q > 8'h01 || ready_in)) begin
      act_q <= (cnt_q != 8'hc8);
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // idle data shows the inverse pattern, never a stale byte
  assign valid_out = act_q && cnt_q < 8'h02;
  assign data_out = valid_out ? {4'ha, cnt_q[3:0]} : ~{4'ha, cnt_q[3:0]};
  assign done_out = act_q && cnt_q == 8'hc8;
  assign st_out = 8'h40;
  assign sector_out = 8'h04; // differs from the requested sector so the source shows
  assign sink_ready_out = cnt_q[0];
endmodule
`default_nettype wire

/* File: ms_delay_timer.sv */
// millisecond delay timer with its own prescaler
`timescale 1ns/1ps
`default_nettype none
module ms_delay_timer #(
  parameter int unsigned CYC_PER_MS = 250000
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // control
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic [7:0] ms_in,
  // status
  output logic busy_out,
  output logic expired_out
);
  localparam int PW = $clog2(CYC_PER_MS);
  logic [PW-1:0] pre_q;
  logic [7:0] left_q;

  // prescaler restarts on start so the first millisecond is whole
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      busy_out <= 1'b0;
      expired_out <= 1'b0;
      pre_q <= '0;
      left_q <= 8'h00;
    end else begin
      expired_out <= 1'b0;
      if (abort_in) begin
        busy_out <= 1'b0;
      end else if (start_in) begin
        busy_out <= 1'b1;
        pre_q <= '0;
        left_q <= (ms_in == 8'h00) ? 8'h01 : ms_in; // zero would wrap and run 256 ms
      end else if (busy_out) begin
        if (pre_q == PW'(CYC_PER_MS - 1)) begin
          pre_q <= '0;
          if (left_q == 8'h01) begin
            busy_out <= 1'b0;
            expired_out <= 1'b1;
          end else begin
            left_q <= left_q - 8'h01;
          end
        end else begin
          pre_q <= pre_q + 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire
